//--- src/hpbsc_sec_ctl.sv
// Downstream control of a hub-to-PCI bridge: bus range check, burst timer,
// I/O window decode and downstream error status, reached over APB.
// Assumes PCI pins are asynchronous to pclk; hub-side ports are on pclk.
//
// Function
// - Highest downstream bus number, software-writable byte, resets to zero.
// - Attached downstream bus number, writable byte, low end of range.
// - Type 1 config to bus outside range answers master abort.
// - Burst counter loads at master start, counts down from FRAME#.
// - Grant removed: FRAME# ends at expiry; grant kept: burst continues.
// - Latency field bits 7:3, eight PCI clocks per count.
// - I/O base bits 7:4 give address 15:12, low bits zero.
// - I/O limit bits 7:4 give address 15:12, 4 KB aligned.
// - Base and limit bits 3:0 read zero; upper I/O words read-only (not mapped here: an access to them answers pslverr).
// - Status: write one clears, zero keeps, resets to 0280h.
// - Bit 15 sets on PCI parity error, sticky.
// - Bit 14 sets on SERR# seen, sticky.
// - Bit 13 sets when forwarded cycle is master-aborted.
// - Bit 12 sets when forwarded cycle is target-aborted.
// - Completion-required target abort sets primary flag, returns abort.
// - Status bit 11 reads zero always.
//
// Register access over APB was decided locally.
`include "hpbsc_defines.svh"
module hpbsc_sec_ctl #(
   parameter int AW = 12,
   parameter int LAT_W = 5,
   parameter int CNT_W = 8
) (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt
   output logic irq,
   // PCI pins
   input wire hpbsc_pkg::hpbsc_pins_t pci_pins,
   output logic frame_n_o,
   output logic frame_oe_n,
   // Hub Type 1 configuration check
   input wire logic cfg_valid,
   input wire logic [7:0] cfg_bus,
   output logic cfg_done,
   output logic cfg_master_abort,
   // Hub I/O decode
   input wire logic io_valid,
   input wire logic [15:0] io_addr,
   output logic io_done,
   output logic io_forward,
   // Downstream master burst
   input wire logic burst_req,
   input wire logic burst_last,
   output logic burst_busy,
   // Forwarded cycle results and hub completion
   input wire hpbsc_pkg::hpbsc_result_t cyc_res,
   output logic cpl_valid,
   output hpbsc_pkg::hpbsc_cpl_t cpl_status
);

   // ***************************************************************
   // Pin synchronisers and PCI clock edge
   // ***************************************************************
   logic [`HPBSC_SYNC_W-1:0] sync1_r, sync2_r;
   logic clk_d_r;
   logic pci_edge, grant_w, pe_evt, se_evt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= '1;
         sync2_r <= '1;
         clk_d_r <= 1'b1;
      end else begin
         sync1_r <= pci_pins;
         sync2_r <= sync1_r;
         clk_d_r <= sync2_r[3];
      end
   end

   assign pci_edge = sync2_r[3] && !clk_d_r;
   assign grant_w = !sync2_r[2];
   assign pe_evt = pci_edge && !sync2_r[1];
   assign se_evt = pci_edge && !sync2_r[0];

   // ***************************************************************
   // APB access and registers
   // ***************************************************************
   logic setup_w, wr_w;
   logic [`HPBSC_IDX_W-1:0] idx_w;
   logic [7:0] att_r, high_r, burst_r, iob_r, iol_r;
   logic [15:0] sts_r, mask_r, sts_set;
   logic tai_r, mapped_w;
   logic [31:0] rd_nxt;
   logic [LAT_W-1:0] lat_w;

   assign idx_w = paddr[AW-1:2];
   assign setup_w = psel && !penable;
   assign wr_w = psel && penable && pwrite;
   assign pready = 1'b1;
   assign lat_w = burst_r[`HPBSC_LAT_HI:`HPBSC_LAT_LO];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         att_r <= `HPBSC_RST_BYTE;
         high_r <= `HPBSC_RST_BYTE;
         burst_r <= `HPBSC_RST_BYTE;
         iob_r <= `HPBSC_RST_BYTE;
         iol_r <= `HPBSC_RST_BYTE;
         mask_r <= `HPBSC_RST_MASK;
      end else if (wr_w) begin
         case (idx_w)
            `HPBSC_IDX_ATT: att_r <= pwdata[7:0];
            `HPBSC_IDX_HIGH: high_r <= pwdata[7:0];
            `HPBSC_IDX_BURST: begin
               burst_r[`HPBSC_LAT_HI:`HPBSC_LAT_LO] <=
                  pwdata[`HPBSC_LAT_HI:`HPBSC_LAT_LO];
            end
            `HPBSC_IDX_IOB: begin
               iob_r[`HPBSC_IO_HI:`HPBSC_IO_LO] <=
                  pwdata[`HPBSC_IO_HI:`HPBSC_IO_LO];
            end
            `HPBSC_IDX_IOL: begin
               iol_r[`HPBSC_IO_HI:`HPBSC_IO_LO] <=
                  pwdata[`HPBSC_IO_HI:`HPBSC_IO_LO];
            end
            `HPBSC_IDX_MASK: mask_r <= pwdata[15:0] & `HPBSC_STS_CLR;
            default: begin
            end
         endcase
      end
   end

   // Error status: events win over a clearing write in the same cycle
   always_comb begin
      sts_set = '0;
      sts_set[`HPBSC_STS_PE] = pe_evt;
      sts_set[`HPBSC_STS_SE] = se_evt;
      sts_set[`HPBSC_STS_MA] = cyc_res.done && cyc_res.master_abort;
      sts_set[`HPBSC_STS_TA] = cyc_res.done && cyc_res.target_abort;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sts_r <= `HPBSC_RST_STS;
      end else if (wr_w && idx_w == `HPBSC_IDX_STS) begin
         sts_r <= sts_set | (sts_r & ~(pwdata[15:0] & `HPBSC_STS_CLR))
            | (`HPBSC_RST_STS & ~`HPBSC_STS_CLR);
      end else begin
         sts_r <= sts_r | sts_set;
      end
   end

   // Primary-side target abort issued flag, write one to clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tai_r <= 1'b0;
      end else if (cyc_res.done && cyc_res.target_abort
                   && cyc_res.cpl_req) begin
         tai_r <= 1'b1;
      end else if (wr_w && idx_w == `HPBSC_IDX_PSTS
                   && pwdata[`HPBSC_PSTS_TAI]) begin
         tai_r <= 1'b0;
      end
   end

   always_comb begin
      rd_nxt = '0;
      mapped_w = 1'b1;
      case (idx_w)
         `HPBSC_IDX_ATT: rd_nxt[7:0] = att_r;
         `HPBSC_IDX_HIGH: rd_nxt[7:0] = high_r;
         `HPBSC_IDX_BURST: rd_nxt[7:0] = burst_r;
         `HPBSC_IDX_IOB: begin
            rd_nxt[7:0] = {iob_r[`HPBSC_IO_HI:`HPBSC_IO_LO],
                           `HPBSC_IO_CAP};
         end
         `HPBSC_IDX_IOL: begin
            rd_nxt[7:0] = {iol_r[`HPBSC_IO_HI:`HPBSC_IO_LO],
                           `HPBSC_IO_CAP};
         end
         `HPBSC_IDX_STS: begin
            rd_nxt[15:0] = sts_r;
            rd_nxt[`HPBSC_STS_RO] = 1'b0;
         end
         `HPBSC_IDX_MASK: rd_nxt[15:0] = mask_r;
         `HPBSC_IDX_PSTS: rd_nxt[`HPBSC_PSTS_TAI] = tai_r;
         default: mapped_w = 1'b0;
      endcase
   end

   // Read data and error are prepared during the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (setup_w) begin
         prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
         pslverr <= !mapped_w;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(sts_r & mask_r);
      end
   end

   // ***************************************************************
   // Hub-side decodes and completions
   // ***************************************************************
   logic cfg_in_range, io_hit;

   assign cfg_in_range = (cfg_bus >= att_r) && (cfg_bus <= high_r);
   // Limit low bits are all ones, so a 4-bit inclusive compare suffices
   assign io_hit = (io_addr[15:12] >= iob_r[`HPBSC_IO_HI:`HPBSC_IO_LO])
      && (io_addr[15:12] <= iol_r[`HPBSC_IO_HI:`HPBSC_IO_LO]);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_done <= 1'b0;
         cfg_master_abort <= 1'b0;
      end else begin
         cfg_done <= cfg_valid;
         cfg_master_abort <= cfg_valid && !cfg_in_range;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         io_done <= 1'b0;
         io_forward <= 1'b0;
      end else begin
         io_done <= io_valid;
         io_forward <= io_valid && io_hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpl_valid <= 1'b0;
         cpl_status <= hpbsc_pkg::HPBSC_CPL_OK;
      end else begin
         cpl_valid <= cyc_res.done && cyc_res.cpl_req;
         if (cyc_res.done && cyc_res.target_abort) begin
            cpl_status <= hpbsc_pkg::HPBSC_CPL_TA;
         end else if (cyc_res.done && cyc_res.master_abort) begin
            cpl_status <= hpbsc_pkg::HPBSC_CPL_MA;
         end else if (cyc_res.done) begin
            cpl_status <= hpbsc_pkg::HPBSC_CPL_OK;
         end
      end
   end

   // ***************************************************************
   // Downstream burst timer
   // ***************************************************************
   logic [CNT_W-1:0] tmr_cnt;

   hpbsc_burst_timer #(
      .LAT_W(LAT_W),
      .CNT_W(CNT_W)
   ) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .pci_edge(pci_edge),
      .start_req(burst_req),
      .last(burst_last),
      .grant(grant_w),
      .lat(lat_w),
      .busy(burst_busy),
      .cnt_r(tmr_cnt),
      .frame_n_o(frame_n_o),
      .frame_oe_n(frame_oe_n)
   );

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   high_write_a: assert property (
      wr_w && idx_w == `HPBSC_IDX_HIGH |=> high_r == $past(pwdata[7:0]))
      else $error("highest bus write not stored");

   cfg_range_a: assert property (
      cfg_valid && cfg_in_range |=> cfg_done && !cfg_master_abort)
      else $error("in-range config cycle aborted");

   cfg_abort_a: assert property (
      cfg_valid && (cfg_bus < att_r || cfg_bus > high_r)
      |=> cfg_done && cfg_master_abort)
      else $error("out-of-range config cycle not aborted");

   burst_load_a: assert property (
      $fell(frame_n_o) |-> tmr_cnt == CNT_W'({lat_w, 3'b000}))
      else $error("burst counter not loaded at frame start");

   burst_expiry_a: assert property (
      burst_busy && pci_edge && tmr_cnt == '0 && !grant_w
      |=> frame_n_o && !burst_busy)
      else $error("frame kept after expiry without grant");

   burst_keep_a: assert property (
      burst_busy && pci_edge && tmr_cnt == '0 && grant_w && !burst_last
      |=> !frame_n_o)
      else $error("frame dropped while grant held");

   io_window_a: assert property (
      io_valid |=> io_done && io_forward == $past(io_hit))
      else $error("I/O window decode wrong");

   io_low_a: assert property (
      psel && penable && !pwrite
      && (idx_w == `HPBSC_IDX_IOB || idx_w == `HPBSC_IDX_IOL)
      |-> prdata[3:0] == 4'h0)
      else $error("I/O capability bits not zero");

   sts_clear_a: assert property (
      wr_w && idx_w == `HPBSC_IDX_STS && pwdata[`HPBSC_STS_SE] && !se_evt
      |=> !sts_r[`HPBSC_STS_SE])
      else $error("write one did not clear status");

   parity_set_a: assert property (
      pe_evt |=> sts_r[`HPBSC_STS_PE]
      ##1 (sts_r[`HPBSC_STS_PE] || $past(wr_w && idx_w == `HPBSC_IDX_STS)))
      else $error("parity error not sticky");

   serr_set_a: assert property (
      se_evt |=> sts_r[`HPBSC_STS_SE])
      else $error("system error not recorded");

   mabort_set_a: assert property (
      cyc_res.done && cyc_res.master_abort |=> sts_r[`HPBSC_STS_MA])
      else $error("master abort not recorded");

   tabort_set_a: assert property (
      cyc_res.done && cyc_res.target_abort |=> sts_r[`HPBSC_STS_TA])
      else $error("target abort not recorded");

   tabort_cpl_a: assert property (
      cyc_res.done && cyc_res.target_abort && cyc_res.cpl_req
      |=> cpl_valid && cpl_status == hpbsc_pkg::HPBSC_CPL_TA && tai_r)
      else $error("target abort completion missing");

   sts_ro_a: assert property (
      psel && penable && !pwrite && idx_w == `HPBSC_IDX_STS
      |-> prdata[`HPBSC_STS_RO] == 1'b0)
      else $error("status bit 11 not zero");

   cfg_abort_c: cover property (cfg_valid && !cfg_in_range);
   burst_expiry_c: cover property (
      burst_busy && pci_edge && tmr_cnt == '0 && !grant_w);
   tabort_cpl_c: cover property (
      cyc_res.done && cyc_res.target_abort && cyc_res.cpl_req);
   irq_c: cover property ($rose(irq));

endmodule : hpbsc_sec_ctl

//--- src/hpbsc_defines.svh
// Offsets, field positions and reset values of the downstream control block.
// Assumes inclusion by its bare name from every design file that needs it.
`ifndef HPBSC_DEFINES_SVH
`define HPBSC_DEFINES_SVH

// ***************************************************************
// Register word indices (byte address is four times the index)
// ***************************************************************
`define HPBSC_IDX_W 10
`define HPBSC_IDX_ATT 10'h019
`define HPBSC_IDX_HIGH 10'h01A
`define HPBSC_IDX_BURST 10'h01B
`define HPBSC_IDX_IOB 10'h01C
`define HPBSC_IDX_IOL 10'h01D
`define HPBSC_IDX_STS 10'h01E
`define HPBSC_IDX_MASK 10'h040
`define HPBSC_IDX_PSTS 10'h042

// ***************************************************************
// Reset values and fields
// ***************************************************************
`define HPBSC_RST_BYTE 8'h00
`define HPBSC_RST_STS 16'h0280
`define HPBSC_RST_MASK 16'h0000
`define HPBSC_STS_PE 15
`define HPBSC_STS_SE 14
`define HPBSC_STS_MA 13
`define HPBSC_STS_TA 12
`define HPBSC_STS_RO 11
`define HPBSC_STS_CLR 16'hF000
`define HPBSC_PSTS_TAI 0
`define HPBSC_LAT_HI 7
`define HPBSC_LAT_LO 3
`define HPBSC_LAT_SHIFT 3
`define HPBSC_IO_HI 7
`define HPBSC_IO_LO 4
`define HPBSC_IO_CAP_HI 3
`define HPBSC_IO_CAP 4'h0
`define HPBSC_SYNC_W 4

`endif

//--- src/hpbsc_pkg.sv
// Types shared by the downstream control block and its burst timer.
// Assumes nothing beyond a SystemVerilog compiler.
package hpbsc_pkg;

   // Raw PCI-side pins, asynchronous to pclk
   typedef struct packed {
      logic clk;
      logic gnt_n;
      logic perr_n;
      logic serr_n;
   } hpbsc_pins_t;

   // Result of a forwarded cycle, reported by the PCI master logic
   typedef struct packed {
      logic done;
      logic master_abort;
      logic target_abort;
      logic cpl_req;
   } hpbsc_result_t;

   typedef enum logic [1:0] {
      HPBSC_CPL_OK,
      HPBSC_CPL_MA,
      HPBSC_CPL_TA
   } hpbsc_cpl_t;

   typedef enum logic {
      HPBSC_BT_IDLE,
      HPBSC_BT_BURST
   } hpbsc_bt_state_t;

endpackage : hpbsc_pkg

//--- src/hpbsc_burst_timer.sv
// Burst latency counter and FRAME# ownership for downstream master bursts.
// Assumes pci_edge marks one pclk cycle per synchronised PCI clock edge.
`include "hpbsc_defines.svh"
module hpbsc_burst_timer #(
   parameter int LAT_W = 5,
   parameter int CNT_W = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic pci_edge,
   input wire logic start_req,
   input wire logic last,
   input wire logic grant,
   input wire logic [LAT_W-1:0] lat,
   // Status and pin
   output logic busy,
   output logic [CNT_W-1:0] cnt_r,
   output logic frame_n_o,
   output logic frame_oe_n
);

   hpbsc_pkg::hpbsc_bt_state_t state_r, state_nxt;
   logic [CNT_W-1:0] load_w;

   assign load_w = CNT_W'({lat, {`HPBSC_LAT_SHIFT{1'b0}}});
   assign busy = (state_r == hpbsc_pkg::HPBSC_BT_BURST);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         hpbsc_pkg::HPBSC_BT_IDLE: begin
            if (pci_edge && start_req && grant) begin
               state_nxt = hpbsc_pkg::HPBSC_BT_BURST;
            end
         end
         hpbsc_pkg::HPBSC_BT_BURST: begin
            // Expiry ends the burst only once the grant has gone
            if (pci_edge && (last || (cnt_r == '0 && !grant))) begin
               state_nxt = hpbsc_pkg::HPBSC_BT_IDLE;
            end
         end
         default: begin
            state_nxt = hpbsc_pkg::HPBSC_BT_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= hpbsc_pkg::HPBSC_BT_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Loaded as FRAME# asserts, then counts down on each PCI clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
      end else if (!busy && state_nxt == hpbsc_pkg::HPBSC_BT_BURST) begin
         cnt_r <= load_w;
      end else if (busy && pci_edge && cnt_r != '0) begin
         cnt_r <= cnt_r - CNT_W'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_n_o <= 1'b1;
         frame_oe_n <= 1'b1;
      end else begin
         frame_n_o <= (state_nxt != hpbsc_pkg::HPBSC_BT_BURST);
         frame_oe_n <= (state_nxt != hpbsc_pkg::HPBSC_BT_BURST);
      end
   end

endmodule : hpbsc_burst_timer

//--- dv/hpbsc_pci_agent.sv
// PCI-side agents: PCI clock, internal grant, PERR# and SERR# pulses.
// Assumes the bench raises run around PCI activity; the clock rests low else.
module hpbsc_pci_agent (
   // Control from the bench
   input wire logic run,
   input wire logic gnt,
   input wire logic perr,
   input wire logic serr,
   // Pins toward the block
   output hpbsc_pkg::hpbsc_pins_t pins
);
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_r = 1'b0;
   logic gnt_n_r = 1'b1;
   logic perr_n_r = 1'b1;
   logic serr_n_r = 1'b1;
   // ***************************************************************
   // Clock, 125 ns period, only while run is high
   // ***************************************************************
   initial begin
      forever begin
         #62.5;
         clk_r = run ? ~clk_r : 1'b0;
      end
   end
   // Agents launch on the falling edge; pulled-up lines rest high
   always @(negedge clk_r) begin
      gnt_n_r <= ~gnt;
      perr_n_r <= ~perr;
      serr_n_r <= ~serr;
   end
   assign pins = {clk_r, gnt_n_r, perr_n_r, serr_n_r};
endmodule : hpbsc_pci_agent

//--- dv/testbench.sv
// Self-checking bench: APB registers, range check, I/O decode, status, burst.
// Assumes the PCI agent model drives the block's PCI pins.
`include "hpbsc_defines.svh"
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic frame_n_o, frame_oe_n, cfg_valid, cfg_done, cfg_master_abort;
   logic io_valid, io_done, io_forward, burst_req, burst_last, burst_busy;
   logic [7:0] cfg_bus;
   logic [15:0] io_addr;
   logic cpl_valid, run, gnt, perr, serr;
   hpbsc_pkg::hpbsc_pins_t pci_pins;
   hpbsc_pkg::hpbsc_result_t cyc_res;
   hpbsc_pkg::hpbsc_cpl_t cpl_status;
   int error_cnt, n_checks;
   hpbsc_sec_ctl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .irq, .pci_pins, .frame_n_o,
      .frame_oe_n, .cfg_valid, .cfg_bus, .cfg_done, .cfg_master_abort,
      .io_valid, .io_addr, .io_done, .io_forward, .burst_req, .burst_last,
      .burst_busy, .cyc_res, .cpl_valid, .cpl_status);
   hpbsc_pci_agent PCI (.run, .gnt, .perr, .serr, .pins(pci_pins));
   // ***************************************************************
   // Helpers
   // ***************************************************************
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [32:0] got, input logic [32:0] e,
                      input string m);
      n_checks++;
      if (got !== e) begin
         error_cnt++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, e);
      end
   endtask : chk
   task automatic apb(input logic [9:0] ix, input logic wr,
                      input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {ix, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20) chk(0, 1, "apb no ready");
   endtask : apb
   task automatic rchk(input logic [9:0] ix, input logic [31:0] e);
      apb(ix, 1'b0, 32'h0);
      chk({err, rd}, {1'b0, e}, $sformatf("read %h", ix));
   endtask : rchk
   function automatic logic exp_abort(logic [7:0] a, h, b);
      return !(b >= a && b <= h);
   endfunction : exp_abort
   function automatic logic exp_fwd(logic [7:0] bs, lm, logic [15:0] ad);
      return ad[15:12] >= bs[7:4] && ad[15:12] <= lm[7:4];
   endfunction : exp_fwd
   task automatic probe(input logic io, input logic [15:0] v, input logic e);
      @(posedge pclk);
      cfg_valid <= ~io;
      io_valid <= io;
      cfg_bus <= v[7:0];
      io_addr <= v;
      @(posedge pclk);
      cfg_valid <= 1'b0;
      io_valid <= 1'b0;
      #1;
      if (io) chk({io_done, io_forward}, {1'b1, e}, "io decode");
      else chk({cfg_done, cfg_master_abort}, {1'b1, e}, "cfg range");
   endtask : probe
   task automatic cyc(input logic ma, input logic ta, input logic cr);
      @(posedge pclk);
      cyc_res <= '{1'b1, ma, ta, cr};
      @(posedge pclk);
      cyc_res <= '0;
      #1;
      chk(cpl_valid, cr, "cpl valid");
      if (cr) chk(cpl_status, ta ? 2'h2 : {1'b0, ma}, "cpl status");
   endtask : cyc
   task automatic burst(input logic [4:0] lat, input logic keep);
      int n;
      apb(`HPBSC_IDX_BURST, 1'b1, {24'h0, lat, 3'b000});
      gnt <= 1'b1;
      burst_req <= 1'b1;
      n = 0;
      while (burst_busy !== 1'b1 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      #1;
      chk({frame_n_o, frame_oe_n}, 2'b00, "frame start");
      @(posedge pclk);
      burst_req <= 1'b0;
      gnt <= keep;
      n = 0;
      while (frame_n_o === 1'b0 && n < 40) begin
         @(posedge pci_pins.clk);
         n++;
      end
      if (keep) begin
         chk(n, 40, "burst kept past expiry");
         @(posedge pclk);
         burst_last <= 1'b1;
         repeat (3) @(posedge pci_pins.clk);
         #1;
         chk({frame_n_o, frame_oe_n, burst_busy}, 3'b110, "burst end");
         burst_last <= 1'b0;
      end else
         chk(n >= lat * 8 && n <= lat * 8 + 3, 1, "burst length");
   endtask : burst
   // ***************************************************************
   // Clock, watchdog and tests
   // ***************************************************************
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   initial begin
      repeat (60000) @(posedge pclk);
      error_cnt++;
      $display("BAD %0t watchdog expired", $time);
      stop_test();
   end
   initial begin
      logic [7:0] a, h;
      logic [7:0] bl [5];
      logic [15:0] al [5];
      logic [9:0] ix [7];
      logic [31:0] mk [7];
      logic [31:0] v;
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {cfg_valid, cfg_bus, io_valid, io_addr, burst_req, burst_last} = '0;
      {run, gnt, perr, serr, error_cnt, n_checks} = '0;
      cyc_res = '0;
      void'($urandom(32'h1CF72C9A));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      ix = '{`HPBSC_IDX_ATT, `HPBSC_IDX_HIGH, `HPBSC_IDX_BURST, `HPBSC_IDX_IOB,
             `HPBSC_IDX_IOL, `HPBSC_IDX_MASK, `HPBSC_IDX_PSTS};
      mk = '{32'hFF, 32'hFF, 32'hF8, 32'hF0, 32'hF0, 32'hF000, 32'h0};
      foreach (ix[i]) rchk(ix[i], 32'h0);
      rchk(`HPBSC_IDX_STS, 32'h0280);
      apb(10'h00C, 1'b0, 32'h0);
      chk({err, rd}, 33'h1_0000_0000, "upper io word unmapped");
      $display("test reset done");
      foreach (ix[i]) begin
         v = $urandom;
         apb(ix[i], 1'b1, v);
         rchk(ix[i], v & mk[i]);
      end
      $display("test registers done");
      repeat (6) begin
         a = 8'($urandom);
         h = a + 8'($urandom % 64);
         apb(`HPBSC_IDX_ATT, 1'b1, {24'h0, a});
         apb(`HPBSC_IDX_HIGH, 1'b1, {24'h0, h});
         bl = '{a, h, a - 8'h01, h + 8'h01, 8'($urandom)};
         foreach (bl[i]) probe(1'b0, {8'h00, bl[i]}, exp_abort(a, h, bl[i]));
         apb(`HPBSC_IDX_IOB, 1'b1, {24'h0, a});
         apb(`HPBSC_IDX_IOL, 1'b1, {24'h0, h});
         al = '{{a[7:4], 12'h000}, {h[7:4], 12'hFFF}, {h[7:4] + 4'h1, 12'h000},
                {a[7:4] - 4'h1, 12'hFFF}, 16'($urandom)};
         foreach (al[i]) probe(1'b1, al[i], exp_fwd(a, h, al[i]));
      end
      $display("test decode done");
      cyc(1'b1, 1'b0, 1'b0);
      cyc(1'b1, 1'b1, 1'b1);
      rchk(`HPBSC_IDX_STS, 32'h3280);
      rchk(`HPBSC_IDX_PSTS, 32'h1);
      apb(`HPBSC_IDX_MASK, 1'b1, 32'h0);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0, "irq masked");
      apb(`HPBSC_IDX_MASK, 1'b1, 32'hF000);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b1, "irq unmasked");
      apb(`HPBSC_IDX_STS, 1'b1, 32'h0FFF);
      rchk(`HPBSC_IDX_STS, 32'h3280);
      apb(`HPBSC_IDX_STS, 1'b1, 32'h2000);
      rchk(`HPBSC_IDX_STS, 32'h1280);
      apb(`HPBSC_IDX_STS, 1'b1, 32'h1000);
      apb(`HPBSC_IDX_PSTS, 1'b1, 32'h1);
      rchk(`HPBSC_IDX_PSTS, 32'h0);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0, "irq cleared");
      $display("test status done");
      run <= 1'b1;
      perr <= 1'b1;
      repeat (40) @(posedge pclk);
      perr <= 1'b0;
      rchk(`HPBSC_IDX_STS, 32'h8280);
      serr <= 1'b1;
      repeat (40) @(posedge pclk);
      serr <= 1'b0;
      // Let the pin rise and pass the synchroniser before clearing the bit
      repeat (40) @(posedge pclk);
      rchk(`HPBSC_IDX_STS, 32'hC280);
      chk(irq, 1'b1, "irq pci event");
      apb(`HPBSC_IDX_STS, 1'b1, 32'hFFFF);
      rchk(`HPBSC_IDX_STS, 32'h0280);
      $display("test pci events done");
      burst_req <= 1'b1;
      repeat (100) @(posedge pclk);
      chk({burst_busy, frame_oe_n}, 2'b01, "no start without grant");
      burst(5'($urandom % 4 + 1), 1'b0);
      burst(5'h01, 1'b1);
      $display("test burst done");
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rchk(`HPBSC_IDX_HIGH, 32'h0);
      $display("test second reset done");
      stop_test();
   end
endmodule : testbench
